// ---- verilog/dsi3cr_pkg.sv ----
// Shared constants, field layout, CRC step and symbol table for the command/response framer
package dsi3cr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] LAST_BIT = 6'h1F;
  localparam int NIBBLE_W = 4;
  localparam int NIBBLES = 8;
  localparam logic [2:0] LAST_NIBBLE = 3'h7;

  // Field positions inside a 32-bit frame, first bit on the wire is bit 31
  localparam int ADDR_LSB = 28;
  localparam int CMD_LSB = 24;
  localparam int HIGH_LSB = 16;
  localparam int LOW_LSB = 8;
  localparam int CRC_LSB = 0;
  localparam int PAIR_LSB = 17;
  localparam int PAIR_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // CRC: x^8+x^5+x^3+x^2+x+1 with an all-ones seed
  localparam logic [7:0] CRC_POLY = 8'h2F;
  localparam logic [7:0] CRC_SEED = 8'hFF;
  localparam logic [7:0] CRC_GOOD = 8'h00;
  localparam logic [7:0] CRC_PAD = 8'h00;

  // Addresses and command codes
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [3:0] CMD_REG_READ = 4'h0;

  // Chip current level codes
  localparam logic [1:0] CHIP_QUIET = 2'h0;
  localparam logic [1:0] CHIP_ONE = 2'h1;
  localparam logic [1:0] CHIP_TWO = 2'h2;
  localparam logic [1:0] LAST_CHIP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // One serial CRC step: the message bit enters at the bottom and the bit
  // leaving the top decides the feedback, so a good frame plus check ends at zero
  function automatic logic [7:0] dsi3cr_crc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7];
    dsi3cr_crc_step = {crc[6:0], bit_in} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  // Nibble to symbol: {first, second, third} chip level codes
  function automatic logic [5:0] dsi3cr_symbol(input logic [3:0] nib);
    case (nib)
      4'h0: dsi3cr_symbol = {CHIP_ONE, CHIP_ONE, CHIP_QUIET};
      4'h1: dsi3cr_symbol = {CHIP_TWO, CHIP_ONE, CHIP_ONE};
      4'h2: dsi3cr_symbol = {CHIP_ONE, CHIP_QUIET, CHIP_TWO};
      4'h3: dsi3cr_symbol = {CHIP_TWO, CHIP_QUIET, CHIP_TWO};
      4'h4: dsi3cr_symbol = {CHIP_ONE, CHIP_QUIET, CHIP_QUIET};
      4'h5: dsi3cr_symbol = {CHIP_TWO, CHIP_ONE, CHIP_TWO};
      4'h6: dsi3cr_symbol = {CHIP_ONE, CHIP_ONE, CHIP_TWO};
      4'h7: dsi3cr_symbol = {CHIP_TWO, CHIP_QUIET, CHIP_ONE};
      4'h8: dsi3cr_symbol = {CHIP_TWO, CHIP_TWO, CHIP_QUIET};
      4'h9: dsi3cr_symbol = {CHIP_TWO, CHIP_ONE, CHIP_QUIET};
      4'hA: dsi3cr_symbol = {CHIP_ONE, CHIP_TWO, CHIP_TWO};
      4'hB: dsi3cr_symbol = {CHIP_TWO, CHIP_TWO, CHIP_ONE};
      4'hC: dsi3cr_symbol = {CHIP_ONE, CHIP_TWO, CHIP_QUIET};
      4'hD: dsi3cr_symbol = {CHIP_TWO, CHIP_QUIET, CHIP_QUIET};
      4'hE: dsi3cr_symbol = {CHIP_ONE, CHIP_QUIET, CHIP_ONE};
      default: dsi3cr_symbol = {CHIP_ONE, CHIP_TWO, CHIP_ONE};
    endcase
  endfunction

endpackage

// ---- verilog/dsi3cr_fifo.sv ----
// Small nibble FIFO with a registered head word
`timescale 1ns/10ps
module dsi3cr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count; // Words held in the array, head register not counted

  wire push = in_valid && in_ready;
  // Refill the head register whenever it is free or being taken
  wire head_free = !out_valid || out_ready;
  wire pop = head_free && (count != '0);

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign empty = (count == '0) && !out_valid;

  // Array write side
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
      if (pop)
        rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head register, so read data leave a flip-flop
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule

// ---- verilog/dsi3cr_framer.sv ----
// Command receive, check and response symbol transmit for command/response mode
`timescale 1ns/10ps
// Functional notes
// - Command: address, code, two bytes, CRC
// - Act only when address matches own
// - CRC over all 32 command bits
// - Bad CRC: drop, no response
// - Seed, shift all bits, zero means good
// - Polynomial 0x2F, all-ones seed
// - Response is 32 bits, five fields
// - Echo command, send own address
// - Upper byte from pair address plus one
// - Lower byte from pair address plus zero
// - One three-chip symbol per nibble
// - Chips take three current levels
// - Fixed nibble to chip table
// - Every symbol starts non-quiescent, changes
// - Exchanges only between master and addressed slave
// - Response CRC, same seed, eight zeros appended
// - Reads to other or global address ignored
module dsi3cr_framer #(
  parameter int CHIP_CYCLES = 16,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_start,
  input wire logic cmd_bit_valid,
  input wire logic cmd_bit,
  input wire logic [3:0] node_address_store,
  output logic [6:0] register_pair_address,
  input wire logic [7:0] upper_register_byte,
  input wire logic [7:0] lower_register_byte,
  output logic cmd_accepted,
  output logic [3:0] cmd_code,
  output logic [7:0] extended_data_byte,
  output logic [7:0] cmd_register_data,
  output logic crc_error,
  output logic frame_dropped,
  output logic [1:0] response_current_unit,
  output logic response_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Framer state machine
  typedef enum logic [2:0] {
    DSI3CR_IDLE = 3'b001,
    DSI3CR_CHECK = 3'b010,
    DSI3CR_PUSH = 3'b100
  } dsi3cr_state_type;

  // Chip transmitter state machine
  typedef enum logic [1:0] {
    DSI3CR_TX_IDLE = 2'b01,
    DSI3CR_TX_CHIP = 2'b10
  } dsi3cr_tx_type;

  localparam int TW = $clog2(CHIP_CYCLES + 1);
  localparam logic [TW-1:0] CHIP_END = TW'(CHIP_CYCLES - 1);

  dsi3cr_state_type state; // Framer state
  dsi3cr_state_type next_state;
  dsi3cr_tx_type tx_state; // Transmitter state
  dsi3cr_tx_type next_tx_state;

  logic [31:0] frame; // Received bits, first bit ends in bit 31
  logic [7:0] crc; // Running check register
  logic [5:0] bit_count; // Bits taken in this frame
  logic frame_done; // Set one cycle after the 32nd bit
  logic [31:0] resp_word; // Response held while it is pushed
  logic [2:0] nib_idx; // Nibble being pushed, counts down
  logic [5:0] symbol; // Chips of the symbol on the wire
  logic [1:0] chip_idx; // Chip within the symbol
  logic [TW-1:0] chip_timer; // Cycles spent in the current chip

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the finished frame
  wire [3:0] rx_addr = frame[dsi3cr_pkg::ADDR_LSB +: 4];
  wire [3:0] rx_cmd = frame[dsi3cr_pkg::CMD_LSB +: 4];
  wire crc_ok = (crc == dsi3cr_pkg::CRC_GOOD);
  wire addr_match = (rx_addr == node_address_store);
  wire global_read = (rx_addr == dsi3cr_pkg::GLOBAL_ADDR)
                   && (rx_cmd == dsi3cr_pkg::CMD_REG_READ);
  wire take_cmd = crc_ok && addr_match && !global_read;

  // Response busy until the last chip has gone out
  wire fifo_empty;
  wire tx_busy = !fifo_empty || (tx_state != DSI3CR_TX_IDLE);

  // FIFO handshakes
  wire push_ready;
  wire push_valid = (state == DSI3CR_PUSH);
  wire [3:0] push_data = resp_word[{nib_idx, 2'b00} +: 4];
  wire sym_valid;
  wire [3:0] sym_nibble;
  wire chip_last_cycle = (chip_timer == CHIP_END);
  wire symbol_end = (tx_state == DSI3CR_TX_CHIP) && chip_last_cycle
                  && (chip_idx == dsi3cr_pkg::LAST_CHIP);
  // Take a new nibble when idle or right at the end of a symbol
  wire sym_ready = (tx_state == DSI3CR_TX_IDLE) || symbol_end;
  wire sym_take = sym_valid && sym_ready;
  // Chip codes of the nibble at the buffer head, named so one chip can be picked
  wire [5:0] sym_lookup = dsi3cr_pkg::dsi3cr_symbol(sym_nibble);

  ////////////////////////////////////////////////////////////////////////////
  // Response CRC: 24 bits then eight zeros through the same register
  function automatic logic [7:0] dsi3cr_resp_crc(input logic [23:0] body);
    logic [31:0] msg;
    logic [7:0] c;
    msg = {body, dsi3cr_pkg::CRC_PAD};
    c = dsi3cr_pkg::CRC_SEED;
    for (int i = 31; i >= 0; i--)
      c = dsi3cr_pkg::dsi3cr_crc_step(c, msg[i]);
    dsi3cr_resp_crc = c;
  endfunction

  wire [23:0] resp_body = {node_address_store, rx_cmd, upper_register_byte,
                           lower_register_byte};
  wire [31:0] next_resp = {resp_body, dsi3cr_resp_crc(resp_body)};

  assign register_pair_address = frame[dsi3cr_pkg::PAIR_LSB +: dsi3cr_pkg::PAIR_W];

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive: shift register, bit counter and CRC
  // 32-bit frame, MSB first
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      frame <= '0;
      crc <= dsi3cr_pkg::CRC_SEED;
      bit_count <= '0;
      frame_done <= 1'b0;
    end
    else if (cmd_start)
    begin
      // A new frame discards whatever partial frame was in progress
      crc <= dsi3cr_pkg::CRC_SEED;
      bit_count <= '0;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= 1'b0;
      // Bits after the 32nd are ignored until the next start
      if (cmd_bit_valid && !bit_count[5])
      begin
        frame <= {frame[30:0], cmd_bit};
        crc <= dsi3cr_pkg::dsi3cr_crc_step(crc, cmd_bit);
        bit_count <= bit_count + 6'h01;
        frame_done <= (bit_count == dsi3cr_pkg::LAST_BIT);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framer next state
  always_comb
  begin
    next_state = state;
    case (state)
      DSI3CR_IDLE:
        if (frame_done && !tx_busy)
          next_state = DSI3CR_CHECK;
      DSI3CR_CHECK:
        next_state = take_cmd ? DSI3CR_PUSH : DSI3CR_IDLE;
      DSI3CR_PUSH:
        if (push_ready && (nib_idx == '0))
          next_state = DSI3CR_IDLE;
      default:
        next_state = DSI3CR_IDLE;
    endcase
  end

  // Framer registers and reporting pulses
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= DSI3CR_IDLE;
      resp_word <= '0;
      nib_idx <= '0;
      cmd_accepted <= 1'b0;
      cmd_code <= '0;
      extended_data_byte <= '0;
      cmd_register_data <= '0;
      crc_error <= 1'b0;
      frame_dropped <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd_accepted <= (state == DSI3CR_CHECK) && take_cmd;
      crc_error <= (state == DSI3CR_CHECK) && !crc_ok;
      // Frames arriving while a response is still going out are lost
      frame_dropped <= (state == DSI3CR_IDLE) && frame_done && tx_busy;
      if ((state == DSI3CR_CHECK) && take_cmd)
      begin
        // Register bytes are sampled here, when decode completes
        resp_word <= next_resp;
        nib_idx <= dsi3cr_pkg::LAST_NIBBLE;
        cmd_code <= rx_cmd;
        extended_data_byte <= frame[dsi3cr_pkg::HIGH_LSB +: 8];
        cmd_register_data <= frame[dsi3cr_pkg::LOW_LSB +: 8];
      end
      else if (push_valid && push_ready)
        nib_idx <= nib_idx - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nibble buffer between framer and chip transmitter
  dsi3cr_fifo #(
    .WIDTH(dsi3cr_pkg::NIBBLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(sym_valid),
    .out_ready(sym_ready),
    .out_data(sym_nibble),
    .empty(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter next state
  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      DSI3CR_TX_IDLE:
        if (sym_valid)
          next_tx_state = DSI3CR_TX_CHIP;
      DSI3CR_TX_CHIP:
        // Back-to-back symbols keep the line busy without a gap
        if (symbol_end && !sym_valid)
          next_tx_state = DSI3CR_TX_IDLE;
      default:
        next_tx_state = DSI3CR_TX_IDLE;
    endcase
  end

  // Chip sequencing and current level output
  // three chips per nibble
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_state <= DSI3CR_TX_IDLE;
      symbol <= '0;
      chip_idx <= '0;
      chip_timer <= '0;
    end
    else
    begin
      tx_state <= next_tx_state;
      if (sym_take)
      begin
        symbol <= sym_lookup;
        chip_idx <= '0;
        chip_timer <= '0;
      end
      else if (tx_state == DSI3CR_TX_CHIP)
      begin
        chip_timer <= chip_last_cycle ? '0 : chip_timer + TW'(1);
        if (chip_last_cycle)
          chip_idx <= chip_idx + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      response_current_unit <= dsi3cr_pkg::CHIP_QUIET;
    else if (next_tx_state != DSI3CR_TX_CHIP)
      response_current_unit <= dsi3cr_pkg::CHIP_QUIET;
    else if (sym_take)
      response_current_unit <= sym_lookup[5:4];
    else if (chip_last_cycle)
      response_current_unit <= (chip_idx == 2'h0) ? symbol[3:2] : symbol[1:0];
  end

  assign response_active = (tx_state == DSI3CR_TX_CHIP);
endmodule

// ---- bench/dsi3cr_framer_asserts.sv ----
// Port-level checks on the command/response framer
`timescale 1ns/10ps
module dsi3cr_framer_asserts #(
  parameter int CHIP_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_start,
  input wire logic cmd_bit_valid,
  input wire logic cmd_bit,
  input wire logic [3:0] node_address_store,
  input wire logic cmd_accepted,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] extended_data_byte,
  input wire logic [7:0] cmd_register_data,
  input wire logic crc_error,
  input wire logic [1:0] response_current_unit,
  input wire logic response_active
);
  ////////////////////////////////////////////////////////////////////////////
  // Bits taken so far, saturating at 32
  logic [5:0] taken;
  // Serial image and the last whole frame
  logic [31:0] shift;
  logic [31:0] last;
  // Cycles spent in the present response
  int act_n;

  // Keep a frozen copy, the next frame may already be shifting in
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || cmd_start)
      taken <= 6'h00;
    else if (cmd_bit_valid && taken < 6'h20)
    begin
      taken <= taken + 6'h01;
      shift <= {shift[30:0], cmd_bit};
      if (taken == 6'h1F)
        last <= {shift[30:0], cmd_bit};
    end
  end

  // Response length counter, cleared while idle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !response_active)
      act_n <= 0;
    else
      act_n <= act_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_addr_match: assert property (cmd_accepted |-> last[31:28] == node_address_store)
    else $error("frame for another node accepted");
  a_global_read: assert property (cmd_accepted |-> last[31:24] != 8'h00)
    else $error("global read accepted");
  a_field_hold: assert property (cmd_accepted |=>
    {cmd_code, extended_data_byte, cmd_register_data} == last[27:8])
    else $error("command fields differ from frame");
  a_err_silent: assert property (crc_error && !response_active |-> !response_active [*8])
    else $error("response after bad check value");
  a_resp_starts: assert property (cmd_accepted |-> ##[1:6] response_active)
    else $error("no response after accept");
  a_first_chip: assert property ($rose(response_active) |->
    response_current_unit != dsi3cr_pkg::CHIP_QUIET)
    else $error("response opens on quiescent level");
  a_quiet_idle: assert property (!response_active |-> response_current_unit == 2'h0)
    else $error("current drawn while idle");
  a_level_legal: assert property (response_current_unit != 2'h3)
    else $error("illegal current level");
  a_chip_hold: assert property (response_active && (act_n % CHIP_CYCLES) != 0 |->
    $stable(response_current_unit))
    else $error("chip level changed inside a chip");
  a_frame_len: assert property ($fell(response_active) |-> act_n == 24 * CHIP_CYCLES)
    else $error("response length wrong");
endmodule

bind dsi3cr_framer dsi3cr_framer_asserts #(.CHIP_CYCLES(CHIP_CYCLES)) u_asserts (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
  .cmd_bit_valid(cmd_bit_valid), .cmd_bit(cmd_bit), .node_address_store(node_address_store),
  .cmd_accepted(cmd_accepted), .cmd_code(cmd_code), .extended_data_byte(extended_data_byte),
  .cmd_register_data(cmd_register_data), .crc_error(crc_error),
  .response_current_unit(response_current_unit), .response_active(response_active));

// ---- bench/dsi3cr_master_model.sv ----
// Bus master model: sends command frames, records response chips
`timescale 1ns/10ps
module dsi3cr_master_model #(
  parameter int CHIP_CYCLES = 2
) (
  input wire logic sys_clk,
  output logic cmd_start,
  output logic cmd_bit_valid,
  output logic cmd_bit,
  input wire logic [1:0] response_current_unit,
  input wire logic response_active,
  output logic resp_valid,
  output logic [47:0] resp_chips
);
  // Cycles seen in the present response
  int k = 0;

  initial
  begin
    cmd_start = 1'b0;
    cmd_bit_valid = 1'b0;
    cmd_bit = 1'b0;
    resp_valid = 1'b0;
    resp_chips = '0;
  end

  task automatic send_frame(input logic [31:0] f, input int gap);
    @(posedge sys_clk);
    #1 cmd_start = 1'b1;
    @(posedge sys_clk);
    #1 cmd_start = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      cmd_bit_valid = 1'b1;
      cmd_bit = f[i];
      @(posedge sys_clk);
      #1;
      // Released line shows the inverse, never a stale value
      if (gap > 0)
      begin
        cmd_bit_valid = 1'b0;
        cmd_bit = ~cmd_bit;
        repeat (gap) @(posedge sys_clk);
        #1;
      end
    end
    if (gap == 0)
    begin
      cmd_bit_valid = 1'b0;
      cmd_bit = ~cmd_bit;
    end
  endtask

  // Take one level per chip at its first cycle; report at the end
  always @(posedge sys_clk)
  begin
    resp_valid <= 1'b0;
    if (response_active === 1'b1)
    begin
      if (k % CHIP_CYCLES == 0)
        resp_chips <= {resp_chips[45:0], response_current_unit};
      k <= k + 1;
    end
    else if (k != 0)
    begin
      k <= 0;
      resp_valid <= 1'b1;
    end
  end
endmodule

// ---- bench/dsi3_cmd_resp_framer_bench.sv ----
// Self-checking bench for the command/response framer
`timescale 1ns/10ps
module dsi3_cmd_resp_framer_bench;
  localparam int CC = 2;
  localparam logic [5:0] SYM [16] = '{6'h14, 6'h25, 6'h12, 6'h22, 6'h10, 6'h26, 6'h16,
    6'h21, 6'h28, 6'h24, 6'h1A, 6'h29, 6'h18, 6'h20, 6'h11, 6'h19};
  // Own, target, code, flip, accept, error, drop
  localparam logic [15:0] TBL [5] = '{16'h550A, 16'h5600, 16'h5000, 16'h0000, 16'h0084};
  logic sys_clk, sys_rst, cmd_start, cmd_bit_valid, cmd_bit;
  logic cmd_accepted, crc_error, frame_dropped, response_active, resp_valid;
  logic [3:0] own, cmd_code;
  logic [6:0] pair;
  logic [7:0] ext_out, dat_out, upper, lower;
  logic [7:0] regmem [256];
  logic [1:0] cur;
  logic [47:0] resp_chips;
  logic [31:0] seed;
  logic [47:0] exp_q [$];
  int mismatches = 0;
  int tests_run = 0;

  // Register file seen by the pair address
  assign upper = regmem[{pair, 1'b1}];
  assign lower = regmem[{pair, 1'b0}];

  dsi3cr_framer #(.CHIP_CYCLES(CC), .FIFO_DEPTH(8)) u_dsi3cr_framer (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
    .cmd_bit_valid(cmd_bit_valid), .cmd_bit(cmd_bit), .node_address_store(own),
    .register_pair_address(pair), .upper_register_byte(upper), .lower_register_byte(lower),
    .cmd_accepted(cmd_accepted), .cmd_code(cmd_code), .extended_data_byte(ext_out),
    .cmd_register_data(dat_out), .crc_error(crc_error), .frame_dropped(frame_dropped),
    .response_current_unit(cur), .response_active(response_active));

  dsi3cr_master_model #(.CHIP_CYCLES(CC)) u_dsi3cr_master_model (
    .sys_clk(sys_clk), .cmd_start(cmd_start), .cmd_bit_valid(cmd_bit_valid),
    .cmd_bit(cmd_bit), .response_current_unit(cur), .response_active(response_active),
    .resp_valid(resp_valid), .resp_chips(resp_chips));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    logic [31:0] m;
    c = 8'hFF;
    m = {d, 8'h00};
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], m[i]} ^ (c[7] ? 8'h2F : 8'h00);
    return c;
  endfunction

  // Chips of a response word, first nibble first
  function automatic logic [47:0] enc(input logic [31:0] w);
    logic [47:0] s;
    s = '0;
    for (int n = 7; n >= 0; n--)
      s = {s[41:0], SYM[w[4*n +: 4]]};
    return s;
  endfunction

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Note the response the device owes, built from own register file
  task automatic owe(input logic [3:0] c, input logic [6:0] p);
    logic [23:0] w;
    w = {own, c, regmem[{p, 1'b1}], regmem[{p, 1'b0}]};
    exp_q.push_back(enc({w, crc8(w)}));
  endtask

  // Send one frame and collect the pulses it causes
  task automatic run_cmd(input logic [31:0] f, input int gap, input logic [2:0] flags);
    logic [2:0] seen;
    seen = 3'h0;
    u_dsi3cr_master_model.send_frame(f, gap);
    repeat (6)
    begin
      seen |= {cmd_accepted, crc_error, frame_dropped};
      @(posedge sys_clk);
      #1;
    end
    chk(seen, flags); // verdict pulses
    if (flags[2])
      chk({cmd_code, ext_out, dat_out}, f[27:8]); // field split
  endtask

  task automatic wait_idle();
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 300 && response_active === 1'b1; i++)
      @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Each finished response is matched against the oldest note
  always @(negedge sys_clk)
  begin
    if (resp_valid)
      chk(resp_chips, exp_q.size() > 0 ? exp_q.pop_front() : {48{1'bx}}); // chips
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    logic [23:0] f;
    logic [15:0] t;
    sys_rst = 1'b1;
    own = 4'h5;
    seed = 32'h000146B3;
    foreach (regmem[i])
    begin
      seed = nxt(seed);
      regmem[i] = seed[7:0];
    end
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    // Known-good check value for a fixed frame body guards the bench's own CRC
    chk(crc8(24'h181186), 8'hB0); // reference value
    // Every code to own node, prompt and slow bit pacing
    for (int c = 0; c < 16; c++)
    begin
      seed = nxt(seed);
      f = {own, c[3:0], seed[15:0]};
      owe(c[3:0], f[15:9]);
      run_cmd({f, crc8(f)}, c % 3, 3'h4);
      wait_idle();
    end
    $display("test 1 done");
    // Bad check value, other node, global reads, global write
    for (int i = 0; i < 5; i++)
    begin
      t = TBL[i];
      own = t[15:12];
      seed = nxt(seed);
      f = {t[11:4], seed[15:0]};
      if (t[2])
        owe(t[7:4], f[15:9]);
      run_cmd({f, crc8(f) ^ {7'h00, t[3]}}, 1, t[2:0]);
      wait_idle();
    end
    $display("test 2 done");
    // Second frame ends while the first answer is still going out
    own = 4'h5;
    f = {own, 4'h0, seed[31:16]};
    owe(4'h0, f[15:9]);
    run_cmd({f, crc8(f)}, 0, 3'h4);
    run_cmd({f, crc8(f)}, 0, 3'h1);
    wait_idle();
    repeat (10) @(posedge sys_clk);
    chk(exp_q.size(), 0); // nothing left owed
    $display("test 3 done");
    tally_and_finish();
  end
endmodule
